// ### rtl/ccpcu_end.sv
// Intentionally empty: no further design content.
`default_nettype none
`default_nettype wire

// ### rtl/ccpcu_pkg.sv
// Types shared by the compare unit files.
`default_nettype none
package ccpcu_pkg;
  typedef enum logic [3:0] {
    MODE_OFF = 4'h0,
    MODE_TOGGLE = 4'h2,
    MODE_SET_HIGH = 4'h8,
    MODE_SET_LOW = 4'h9,
    MODE_SWINT = 4'hA,
    MODE_TRIGGER = 4'hB
  } ccpcu_mode_t;

  typedef struct packed {
    logic o;
    logic oe;
  } ccpcu_pin_t;
endpackage : ccpcu_pkg
`default_nettype wire

// ### rtl/ccpcu_regs.svh
// Register offsets, field positions and reset values of the compare unit.
`ifndef CCPCU_REGS_SVH
`define CCPCU_REGS_SVH

`define CCPCU_OFF_FLAGS1 6'h00
`define CCPCU_OFF_ENABLES1 6'h04
`define CCPCU_OFF_U1_LOW 6'h08
`define CCPCU_OFF_U1_HIGH 6'h0C
`define CCPCU_OFF_U1_CTL 6'h10
`define CCPCU_OFF_U2_LOW 6'h14
`define CCPCU_OFF_U2_HIGH 6'h18
`define CCPCU_OFF_U2_CTL 6'h1C
`define CCPCU_OFF_FLAGS2 6'h20
`define CCPCU_OFF_ENABLES2 6'h24
`define CCPCU_OFF_T3_CTL 6'h28
`define CCPCU_OFF_STATUS 6'h2C

`define CCPCU_BIT_U1_FLAG 2
`define CCPCU_BIT_T1_FLAG 0
`define CCPCU_BIT_U2_FLAG 0
`define CCPCU_BIT_T3_FLAG 1
`define CCPCU_BIT_SEL_LOW 3
`define CCPCU_BIT_SEL_HIGH 6
`define CCPCU_MASK_FLAGS2 8'hDF
`define CCPCU_MASK_CTL 8'h3F

`define CCPCU_RST_REG 8'h00
`define CCPCU_RESP_OKAY 2'h0
`define CCPCU_RESP_SLVERR 2'h2

`endif

// ### rtl/ccpcu_top.sv
// Two-unit output compare / PWM block with an AXI4-Lite register slave.
`include "ccpcu_regs.svh"
`default_nettype none
module ccpcu_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [5:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [5:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Timers and converter
  input wire logic [15:0] first_timer_count,
  input wire logic [15:0] third_timer_count,
  input wire logic timer1_overflow,
  input wire logic timer3_overflow,
  input wire logic [9:0] pwm_base,
  input wire logic pwm_period_end,
  input wire logic adc_enabled,
  output logic timer1_clear,
  output logic timer3_clear,
  output logic adc_start,
  // Port pins
  input wire logic [1:0] port_c_direction,
  input wire logic [1:0] port_c_data,
  output ccpcu_pkg::ccpcu_pin_t unit1_pin,
  output ccpcu_pkg::ccpcu_pin_t unit2_pin,
  // Interrupt requests
  output logic unit1_irq,
  output logic unit2_irq
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] flags1_r;
  logic [7:0] enables1_r;
  logic [7:0] flags2_r;
  logic [7:0] enables2_r;
  logic [7:0] unit1_control_r;
  logic [7:0] unit2_control_r;
  logic [7:0] timer3_control_r;
  logic [15:0] unit1_compare_value_r;
  logic [15:0] unit2_compare_value_r;
  logic [7:0] flags1_nxt;
  logic [7:0] flags2_nxt;
  logic [5:0] awaddr_r;
  logic [7:0] wdata_r;
  logic wbyte_r;

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  logic do_wr;
  logic wr_mapped;
  logic wr_flags1;
  logic wr_enables1;
  logic wr_u1_low;
  logic wr_u1_high;
  logic wr_u1_ctl;
  logic wr_u2_low;
  logic wr_u2_high;
  logic wr_u2_ctl;
  logic wr_flags2;
  logic wr_enables2;
  logic wr_t3_ctl;

  // Both halves of the write are held once both readies have dropped.
  assign do_wr = !awready && !wready && !bvalid;
  assign wr_mapped = awaddr_r <= `CCPCU_OFF_STATUS && awaddr_r[1:0] == 2'h0;
  assign wr_flags1 = do_wr && wbyte_r && awaddr_r == `CCPCU_OFF_FLAGS1;
  assign wr_enables1 = do_wr && wbyte_r && awaddr_r == `CCPCU_OFF_ENABLES1;
  assign wr_u1_low = do_wr && wbyte_r && awaddr_r == `CCPCU_OFF_U1_LOW;
  assign wr_u1_high = do_wr && wbyte_r && awaddr_r == `CCPCU_OFF_U1_HIGH;
  assign wr_u1_ctl = do_wr && wbyte_r && awaddr_r == `CCPCU_OFF_U1_CTL;
  assign wr_u2_low = do_wr && wbyte_r && awaddr_r == `CCPCU_OFF_U2_LOW;
  assign wr_u2_high = do_wr && wbyte_r && awaddr_r == `CCPCU_OFF_U2_HIGH;
  assign wr_u2_ctl = do_wr && wbyte_r && awaddr_r == `CCPCU_OFF_U2_CTL;
  assign wr_flags2 = do_wr && wbyte_r && awaddr_r == `CCPCU_OFF_FLAGS2;
  assign wr_enables2 = do_wr && wbyte_r && awaddr_r == `CCPCU_OFF_ENABLES2;
  assign wr_t3_ctl = do_wr && wbyte_r && awaddr_r == `CCPCU_OFF_T3_CTL;

  // ----------------------------------------
  // Compare units
  // ----------------------------------------
  logic u1_t3;
  logic u2_t3;
  logic [15:0] u1_count;
  logic [15:0] u2_count;
  logic u1_match;
  logic u2_match;
  logic u1_trig;
  logic u2_trig;
  logic u1_own;
  logic u2_own;
  logic u1_latch;
  logic u2_latch;

  assign u1_t3 = timer3_control_r[`CCPCU_BIT_SEL_HIGH];
  assign u2_t3 = u1_t3 || timer3_control_r[`CCPCU_BIT_SEL_LOW];
  assign u1_count = u1_t3 ? third_timer_count : first_timer_count;
  assign u2_count = u2_t3 ? third_timer_count : first_timer_count;

  ccpcu_unit u_unit1 (
    .aclk(aclk),
    .aresetn(aresetn),
    .mode(unit1_control_r[3:0]),
    .value(unit1_compare_value_r),
    .duty_lsb(unit1_control_r[5:4]),
    .count(u1_count),
    .pwm_base(pwm_base),
    .pwm_period_end(pwm_period_end),
    .match_evt(u1_match),
    .trig_evt(u1_trig),
    .pin_own(u1_own),
    .latch_r(u1_latch)
  );

  ccpcu_unit u_unit2 (
    .aclk(aclk),
    .aresetn(aresetn),
    .mode(unit2_control_r[3:0]),
    .value(unit2_compare_value_r),
    .duty_lsb(unit2_control_r[5:4]),
    .count(u2_count),
    .pwm_base(pwm_base),
    .pwm_period_end(pwm_period_end),
    .match_evt(u2_match),
    .trig_evt(u2_trig),
    .pin_own(u2_own),
    .latch_r(u2_latch)
  );

  // ----------------------------------------
  // Flags: a hardware set wins over a clear
  // ----------------------------------------
  always_comb
  begin
    flags1_nxt = wr_flags1 ? wdata_r : flags1_r;
    flags1_nxt[`CCPCU_BIT_U1_FLAG] = flags1_nxt[`CCPCU_BIT_U1_FLAG] | u1_match;
    // Only overflow or a register write sets the timer flags, so trigger clears stay silent.
    flags1_nxt[`CCPCU_BIT_T1_FLAG] = flags1_nxt[`CCPCU_BIT_T1_FLAG] | timer1_overflow;
    flags2_nxt = (wr_flags2 ? wdata_r : flags2_r) & `CCPCU_MASK_FLAGS2;
    flags2_nxt[`CCPCU_BIT_U2_FLAG] = flags2_nxt[`CCPCU_BIT_U2_FLAG] | u2_match;
    flags2_nxt[`CCPCU_BIT_T3_FLAG] = flags2_nxt[`CCPCU_BIT_T3_FLAG] | timer3_overflow;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      flags1_r <= `CCPCU_RST_REG;
      flags2_r <= `CCPCU_RST_REG;
      enables1_r <= `CCPCU_RST_REG;
      enables2_r <= `CCPCU_RST_REG;
      unit1_control_r <= `CCPCU_RST_REG;
      unit2_control_r <= `CCPCU_RST_REG;
      timer3_control_r <= `CCPCU_RST_REG;
    end
    else
    begin
      flags1_r <= flags1_nxt;
      flags2_r <= flags2_nxt;
      if (wr_enables1)
        enables1_r <= wdata_r;
      if (wr_enables2)
        enables2_r <= wdata_r & `CCPCU_MASK_FLAGS2;
      if (wr_u1_ctl)
        unit1_control_r <= wdata_r & `CCPCU_MASK_CTL;
      if (wr_u2_ctl)
        unit2_control_r <= wdata_r & `CCPCU_MASK_CTL;
      if (wr_t3_ctl)
        timer3_control_r <= wdata_r;
    end
  end

  // Compare values have no reset so they survive any reset.
  always_ff @(posedge aclk)
  begin
    if (wr_u1_low)
      unit1_compare_value_r[7:0] <= wdata_r;
    if (wr_u1_high)
      unit1_compare_value_r[15:8] <= wdata_r;
    if (wr_u2_low)
      unit2_compare_value_r[7:0] <= wdata_r;
    if (wr_u2_high)
      unit2_compare_value_r[15:8] <= wdata_r;
  end

  // ----------------------------------------
  // Triggers, pins and interrupt requests
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      timer1_clear <= 1'b0;
      timer3_clear <= 1'b0;
      adc_start <= 1'b0;
      unit1_pin <= '0;
      unit2_pin <= '0;
      unit1_irq <= 1'b0;
      unit2_irq <= 1'b0;
    end
    else
    begin
      timer1_clear <= u1_trig || (u2_trig && !u2_t3);
      timer3_clear <= u2_trig && u2_t3;
      adc_start <= u2_trig && adc_enabled;
      // Released pins fall back to the port latch, never to the unit latch.
      unit1_pin.o <= u1_own ? u1_latch : port_c_data[0];
      unit2_pin.o <= u2_own ? u2_latch : port_c_data[1];
      unit1_pin.oe <= !port_c_direction[0];
      unit2_pin.oe <= !port_c_direction[1];
      unit1_irq <= flags1_r[`CCPCU_BIT_U1_FLAG] && enables1_r[`CCPCU_BIT_U1_FLAG];
      unit2_irq <= flags2_r[`CCPCU_BIT_U2_FLAG] && enables2_r[`CCPCU_BIT_U2_FLAG];
    end
  end

  // ----------------------------------------
  // AXI4-Lite handshakes
  // ----------------------------------------
  logic [7:0] rd_byte;
  logic rd_mapped;

  assign rd_mapped = araddr <= `CCPCU_OFF_STATUS && araddr[1:0] == 2'h0;
  assign rd_byte =
    araddr == `CCPCU_OFF_FLAGS1 ? flags1_r :
    araddr == `CCPCU_OFF_ENABLES1 ? enables1_r :
    araddr == `CCPCU_OFF_U1_LOW ? unit1_compare_value_r[7:0] :
    araddr == `CCPCU_OFF_U1_HIGH ? unit1_compare_value_r[15:8] :
    araddr == `CCPCU_OFF_U1_CTL ? unit1_control_r :
    araddr == `CCPCU_OFF_U2_LOW ? unit2_compare_value_r[7:0] :
    araddr == `CCPCU_OFF_U2_HIGH ? unit2_compare_value_r[15:8] :
    araddr == `CCPCU_OFF_U2_CTL ? unit2_control_r :
    araddr == `CCPCU_OFF_FLAGS2 ? flags2_r :
    araddr == `CCPCU_OFF_ENABLES2 ? enables2_r :
    araddr == `CCPCU_OFF_T3_CTL ? timer3_control_r :
    araddr == `CCPCU_OFF_STATUS ? {4'h0, u2_own, u2_latch, u1_own, u1_latch} :
    8'h00;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= `CCPCU_RESP_OKAY;
      awaddr_r <= 6'h00;
      wdata_r <= 8'h00;
      wbyte_r <= 1'b0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        awaddr_r <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready)
      begin
        wdata_r <= wdata[7:0];
        wbyte_r <= wstrb[0];
        wready <= 1'b0;
      end
      if (do_wr)
      begin
        bvalid <= 1'b1;
        bresp <= wr_mapped ? `CCPCU_RESP_OKAY : `CCPCU_RESP_SLVERR;
      end
      if (bvalid && bready)
      begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `CCPCU_RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= {24'h00_0000, rd_byte};
      rresp <= rd_mapped ? `CCPCU_RESP_OKAY : `CCPCU_RESP_SLVERR;
    end
    else if (rvalid && rready)
    begin
      arready <= 1'b1;
      rvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [3:0] m1;
  assign m1 = unit1_control_r[3:0];

  flag_same_edge_a: assert property (@(posedge aclk) disable iff (!aresetn)
    u1_match |=> flags1_r[`CCPCU_BIT_U1_FLAG] && ($past(m1) == 4'h2 ? $changed(u1_latch) :
    $past(m1) == 4'h8 ? u1_latch : $past(m1) == 4'h9 ? !u1_latch : $stable(u1_latch)))
    else $error("unit one flag or pin did not follow the match");
  set_high_a: assert property (@(posedge aclk) disable iff (!aresetn)
    u1_match && m1 == 4'h8 |=> u1_latch ##1 unit1_pin.o == u1_own)
    else $error("set-high match did not raise the pin");
  set_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
    u1_match && m1 == 4'h9 |=> !u1_latch)
    else $error("set-low match did not drop the pin");
  toggle_pin_a: assert property (@(posedge aclk) disable iff (!aresetn)
    u1_match && m1 == 4'h2 |=> u1_latch != $past(u1_latch))
    else $error("toggle match left the pin");
  swint_pin_a: assert property (@(posedge aclk) disable iff (!aresetn)
    m1 == 4'hA && $past(m1) == 4'hA |=> $stable(u1_latch) && !u1_own)
    else $error("software interrupt mode touched the pin");
  zero_mode_a: assert property (@(posedge aclk) disable iff (!aresetn)
    m1 == 4'h0 |=> !u1_latch && unit1_pin.o == $past(port_c_data[0]))
    else $error("cleared control left the latch high");
  t1_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    u1_trig |=> timer1_clear && (!timer3_clear || $past(u2_trig)))
    else $error("unit one trigger did not clear the first timer");
  adc_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    adc_start |-> $past(u2_trig) && $past(adc_enabled))
    else $error("conversion started without an enabled trigger");
  timer_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(flags1_r[`CCPCU_BIT_T1_FLAG]) |-> $past(timer1_overflow) || $past(wr_flags1))
    else $error("timer flag set without overflow");
  exact_eq_a: assert property (@(posedge aclk) disable iff (!aresetn)
    u1_match |-> u1_count == unit1_compare_value_r && !$stable(u1_count))
    else $error("match without a fresh equal count");

  toggle_c: cover property (@(posedge aclk) u1_match && m1 == 4'h2);
  trigger_c: cover property (@(posedge aclk) adc_start && timer3_clear);
  pwm_c: cover property (@(posedge aclk) pwm_period_end && u1_own && m1[3:2] == 2'h3);
endmodule : ccpcu_top
`default_nettype wire

// ### rtl/ccpcu_unit.sv
// One compare/PWM channel: match detection, output latch and PWM duty buffer.
`default_nettype none
module ccpcu_unit (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Configuration
  input wire logic [3:0] mode,
  input wire logic [15:0] value,
  input wire logic [1:0] duty_lsb,
  // Time bases
  input wire logic [15:0] count,
  input wire logic [9:0] pwm_base,
  input wire logic pwm_period_end,
  // Results
  output logic match_evt,
  output logic trig_evt,
  output logic pin_own,
  output logic latch_r
);
  logic [15:0] count_prev_r;
  logic [3:0] mode_prev_r;
  logic [9:0] duty_buf_r;
  logic latch_nxt;
  logic cmp_mode;
  logic pwm_mode;
  logic mode_new;
  logic eq;

  assign pwm_mode = mode[3:2] == 2'h3;
  assign cmp_mode = mode == ccpcu_pkg::MODE_TOGGLE || mode[3:2] == 2'h2;
  assign mode_new = mode != mode_prev_r;
  assign eq = count == value;
  // A held equality acts once; only a new count value re-arms the match.
  // The first cycle out of the off mode is skipped, as its previous count is stale.
  assign match_evt = cmp_mode && eq && count != count_prev_r && mode_prev_r != 4'h0;
  assign trig_evt = match_evt && mode == ccpcu_pkg::MODE_TRIGGER;
  assign pin_own = pwm_mode || (cmp_mode && mode[3:1] != 3'h5);

  always_comb
  begin
    latch_nxt = latch_r;
    if (mode == ccpcu_pkg::MODE_OFF)
      latch_nxt = 1'b0;
    else if (pwm_mode)
    begin
      if (pwm_period_end)
        latch_nxt = {value[7:0], duty_lsb} != 10'h000;
      else if (pwm_base == duty_buf_r)
        latch_nxt = 1'b0;
    end
    else if (mode_new && mode == ccpcu_pkg::MODE_SET_HIGH)
      latch_nxt = 1'b0;
    else if (mode_new && mode == ccpcu_pkg::MODE_SET_LOW)
      latch_nxt = 1'b1;
    else if (match_evt)
    begin
      unique case (mode)
        ccpcu_pkg::MODE_SET_HIGH: latch_nxt = 1'b1;
        ccpcu_pkg::MODE_SET_LOW: latch_nxt = 1'b0;
        ccpcu_pkg::MODE_TOGGLE: latch_nxt = ~latch_r;
        default: latch_nxt = latch_r;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || mode == ccpcu_pkg::MODE_OFF)
    begin
      count_prev_r <= 16'h0000;
      mode_prev_r <= 4'h0;
      duty_buf_r <= 10'h000;
      latch_r <= 1'b0;
    end
    else
    begin
      count_prev_r <= count;
      mode_prev_r <= mode;
      latch_r <= latch_nxt;
      if (pwm_period_end)
        duty_buf_r <= {value[7:0], duty_lsb};
    end
  end
endmodule : ccpcu_unit
`default_nettype wire

// ### verif/ccpcu_timer_model.sv
// Timer pair and PWM timebase model that feeds the compare block.
`default_nettype none
module ccpcu_timer_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bench control
  input wire logic run,
  input wire logic [1:0] load,
  input wire logic [15:0] load_val,
  // Clears from the block
  input wire logic timer1_clear,
  input wire logic timer3_clear,
  // Time bases
  output logic [15:0] first_timer_count,
  output logic [15:0] third_timer_count,
  output logic timer1_overflow,
  output logic timer3_overflow,
  output logic [9:0] pwm_base,
  output logic pwm_period_end
);
  timeunit 1ns;
  timeprecision 1ns;
  // Both timers step on the block clock, as a synchronized timer does.
  always_ff @(posedge aclk)
  begin
    if (!aresetn || timer1_clear)
      first_timer_count <= 16'h0000;
    else if (load[0])
      first_timer_count <= load_val;
    else if (run)
      first_timer_count <= first_timer_count + 16'h0001;
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn || timer3_clear)
      third_timer_count <= 16'h0000;
    else if (load[1])
      third_timer_count <= load_val;
    else if (run)
      third_timer_count <= third_timer_count + 16'h0001;
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pwm_base <= 10'h000;
    else if (run)
      pwm_base <= (pwm_base == 10'h03F) ? 10'h000 : pwm_base + 10'h001;
  end
  assign timer1_overflow = run && (first_timer_count == 16'hFFFF);
  assign timer3_overflow = run && (third_timer_count == 16'hFFFF);
  assign pwm_period_end = run && (pwm_base == 10'h000);
endmodule : ccpcu_timer_model
`default_nettype wire

// ### verif/tb_top.sv
// Self-checking bench for the two-unit compare block.
`include "ccpcu_regs.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk, aresetn = 1'b0;
  logic [5:0] awaddr = 6'h00, araddr = 6'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, unit1_irq, unit2_irq;
  logic [1:0] bresp, rresp;
  logic [15:0] first_timer_count, third_timer_count, load_val = 16'h0000;
  logic timer1_overflow, timer3_overflow, pwm_period_end, timer1_clear, timer3_clear, adc_start;
  logic [9:0] pwm_base;
  logic adc_enabled = 1'b0, run = 1'b0;
  logic [1:0] load = 2'b00, port_c_data = 2'b01;
  logic [1:0] port_c_direction = 2'b00;
  ccpcu_pkg::ccpcu_pin_t unit1_pin, unit2_pin;
  int fails = 0, compares = 0, n_t1 = 0, n_t3 = 0, n_adc = 0, hi, i;
  logic [5:0] rst_regs [8] = '{`CCPCU_OFF_FLAGS1, `CCPCU_OFF_ENABLES1, `CCPCU_OFF_U1_CTL,
    `CCPCU_OFF_U2_CTL, `CCPCU_OFF_FLAGS2, `CCPCU_OFF_ENABLES2, `CCPCU_OFF_T3_CTL,
    `CCPCU_OFF_STATUS};
  ccpcu_pkg::ccpcu_mode_t md [3] = '{ccpcu_pkg::MODE_SET_HIGH, ccpcu_pkg::MODE_SET_LOW,
    ccpcu_pkg::MODE_TOGGLE};
  logic ini [3] = '{1'b0, 1'b1, 1'b0};
  logic [7:0] sel [2] = '{8'h40, 8'h00};
  int et1 [2] = '{1, 2};

  ccpcu_top dut (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .first_timer_count, .third_timer_count, .timer1_overflow, .timer3_overflow,
    .pwm_base, .pwm_period_end, .adc_enabled, .timer1_clear, .timer3_clear, .adc_start,
    .port_c_direction, .port_c_data, .unit1_pin, .unit2_pin, .unit1_irq, .unit2_irq
  );
  ccpcu_timer_model timers (
    .aclk, .aresetn, .run, .load, .load_val, .timer1_clear, .timer3_clear,
    .first_timer_count, .third_timer_count, .timer1_overflow, .timer3_overflow,
    .pwm_base, .pwm_period_end
  );

  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // Pulses are one cycle wide, so one sample per edge counts each once.
  always @(posedge aclk)
  begin
    n_t1 += (timer1_clear === 1'b1);
    n_t3 += (timer3_clear === 1'b1);
    n_adc += (adc_start === 1'b1);
  end

  task automatic tally_and_finish();
    $display("fails=%0d compares=%0d", fails, compares);
    if (fails == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  task automatic give_up();
    fails++;
    tally_and_finish();
  endtask : give_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge aclk);
      if (awready === 1'b1)
        awvalid <= 1'b0;
      if (wready === 1'b1)
        wvalid <= 1'b0;
      if (bvalid === 1'b1)
        break;
    end
    bready <= 1'b0;
    if (n == 40)
      give_up();
    chk({30'h0, bresp}, {30'h0, er});
  endtask : wr

  task automatic rdc(input logic [5:0] a, input logic [31:0] exp, input logic [1:0] er);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge aclk);
      if (arready === 1'b1)
        arvalid <= 1'b0;
      if (rvalid === 1'b1)
        break;
    end
    rready <= 1'b0;
    if (n == 40)
      give_up();
    chk(rdata, exp);
    chk({30'h0, rresp}, {30'h0, er});
  endtask : rdc

  task automatic ld(input int k, input logic [15:0] v);
    @(posedge aclk);
    load[k] <= 1'b1;
    load_val <= v;
    @(posedge aclk);
    load <= 2'b00;
    run <= 1'b1;
  endtask : ld

  // Waits on irq of unit 1 or 2, or on a PWM period end; irq waits stop the timers.
  task automatic wait_sig(input int which);
    int n;
    logic s;
    for (n = 0; n < 300; n++)
    begin
      @(posedge aclk);
      s = (which == 1) ? unit1_irq : (which == 2) ? unit2_irq : pwm_period_end;
      if (s === 1'b1)
        break;
    end
    if (which < 3)
      run <= 1'b0;
    if (n == 300)
      give_up();
  endtask : wait_sig

  // ----------------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (rst_regs[k])
      rdc(rst_regs[k], 32'h0, `CCPCU_RESP_OKAY);
    chk({28'h0, unit1_pin, unit2_pin}, 32'h0000000D);
    rdc(6'h30, 32'h0, `CCPCU_RESP_SLVERR);
    wr(6'h30, 8'hFF, `CCPCU_RESP_SLVERR);
    wr(`CCPCU_OFF_U1_HIGH, 8'h00, `CCPCU_RESP_OKAY);
    wr(`CCPCU_OFF_U1_LOW, 8'h40, `CCPCU_RESP_OKAY);
    wr(`CCPCU_OFF_U1_CTL, 8'hFF, `CCPCU_RESP_OKAY);
    rdc(`CCPCU_OFF_U1_CTL, 32'h3F, `CCPCU_RESP_OKAY);
    wr(`CCPCU_OFF_FLAGS2, 8'hFF, `CCPCU_RESP_OKAY);
    rdc(`CCPCU_OFF_FLAGS2, 32'hDF, `CCPCU_RESP_OKAY);
    wr(`CCPCU_OFF_FLAGS2, 8'h00, `CCPCU_RESP_OKAY);
    wr(`CCPCU_OFF_ENABLES1, 8'h04, `CCPCU_RESP_OKAY);
    wr(`CCPCU_OFF_ENABLES2, 8'h01, `CCPCU_RESP_OKAY);
    for (i = 0; i < 3; i++)
    begin
      wr(`CCPCU_OFF_U1_CTL, 8'h00, `CCPCU_RESP_OKAY);
      wr(`CCPCU_OFF_U1_CTL, {4'h0, md[i]}, `CCPCU_RESP_OKAY);
      repeat (3) @(posedge aclk);
      chk({31'h0, unit1_pin.o}, {31'h0, ini[i]});
      ld(0, 16'h003C);
      wait_sig(1);
      chk({31'h0, unit1_pin.o}, {31'h0, ~ini[i]});
      rdc(`CCPCU_OFF_FLAGS1, 32'h04, `CCPCU_RESP_OKAY);
      chk({31'h0, unit1_irq}, 32'h1);
      rdc(`CCPCU_OFF_STATUS, {30'h0, 1'b1, ~ini[i]}, `CCPCU_RESP_OKAY);
      wr(`CCPCU_OFF_FLAGS1, 8'h00, `CCPCU_RESP_OKAY);
    end
    wr(`CCPCU_OFF_U1_CTL, 8'h00, `CCPCU_RESP_OKAY);
    rdc(`CCPCU_OFF_STATUS, 32'h0, `CCPCU_RESP_OKAY);
    chk({31'h0, unit1_pin.o}, 32'h1);
    wr(`CCPCU_OFF_U1_CTL, 8'h0A, `CCPCU_RESP_OKAY);
    ld(0, 16'h003C);
    wait_sig(1);
    chk({31'h0, unit1_pin.o}, 32'h1);
    rdc(`CCPCU_OFF_STATUS, 32'h0, `CCPCU_RESP_OKAY);
    wr(`CCPCU_OFF_FLAGS1, 8'h00, `CCPCU_RESP_OKAY);
    wr(`CCPCU_OFF_U1_CTL, 8'h0B, `CCPCU_RESP_OKAY);
    ld(0, 16'h003C);
    wait_sig(1);
    chk(n_t1, 1);
    chk({31'h0, first_timer_count < 16'h0040}, 32'h1);
    wr(`CCPCU_OFF_U1_CTL, 8'h00, `CCPCU_RESP_OKAY);
    wr(`CCPCU_OFF_FLAGS1, 8'h00, `CCPCU_RESP_OKAY);
    wr(`CCPCU_OFF_U2_HIGH, 8'h00, `CCPCU_RESP_OKAY);
    wr(`CCPCU_OFF_U2_LOW, 8'h40, `CCPCU_RESP_OKAY);
    for (i = 0; i < 2; i++)
    begin
      adc_enabled <= (i == 0);
      wr(`CCPCU_OFF_T3_CTL, sel[i], `CCPCU_RESP_OKAY);
      wr(`CCPCU_OFF_U2_CTL, 8'h0B, `CCPCU_RESP_OKAY);
      ld(1 - i, 16'h003C);
      wait_sig(2);
      chk(n_t3, 1);
      chk(n_t1, et1[i]);
      chk(n_adc, 1);
      rdc(`CCPCU_OFF_FLAGS2, 32'h01, `CCPCU_RESP_OKAY);
      rdc(`CCPCU_OFF_FLAGS1, 32'h00, `CCPCU_RESP_OKAY);
      wr(`CCPCU_OFF_FLAGS2, 8'h00, `CCPCU_RESP_OKAY);
      wr(`CCPCU_OFF_U2_CTL, 8'h00, `CCPCU_RESP_OKAY);
    end
    // Duty is {8'h04, 2'b10}, 18 base steps high out of 64.
    wr(`CCPCU_OFF_U1_LOW, 8'h04, `CCPCU_RESP_OKAY);
    wr(`CCPCU_OFF_U1_CTL, 8'h2C, `CCPCU_RESP_OKAY);
    run <= 1'b1;
    wait_sig(3);
    wait_sig(3);
    hi = 0;
    repeat (64)
    begin
      @(posedge aclk);
      hi += (unit1_pin.o === 1'b1);
    end
    chk(hi, 18);
    wr(`CCPCU_OFF_U1_CTL, 8'h00, `CCPCU_RESP_OKAY);
    run <= 1'b0;
    rdc(`CCPCU_OFF_STATUS, 32'h0, `CCPCU_RESP_OKAY);
    chk({31'h0, unit1_pin.o}, 32'h1);
    ld(0, 16'hFFFE);
    repeat (4) @(posedge aclk);
    run <= 1'b0;
    rdc(`CCPCU_OFF_FLAGS1, 32'h01, `CCPCU_RESP_OKAY);
    port_c_direction <= 2'b11;
    repeat (2) @(posedge aclk);
    chk({28'h0, unit1_pin, unit2_pin}, 32'h00000008);
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
